// *** adc_conv_regs.svh ***
`ifndef ADC_CONV_REGS_SVH
`define ADC_CONV_REGS_SVH
// ==========================================================
// register offsets
`define MODE_TIMING_ADDR 8'hEF
`define CHAN_CONV_ADDR 8'hD8
`define RESULT_HIGH_ADDR 8'hDA
`define RESULT_LOW_ADDR 8'hD9
`define OFFSET_CAL_ADDR 8'hF1
`define GAIN_CAL_ADDR 8'hF3
// ==========================================================
// reset values
`define MODE_TIMING_RESET 8'h20
`define CHAN_CONV_RESET 8'h00
`define OFFSET_CAL_RESET 8'h80
`define GAIN_CAL_RESET 8'h80
// ==========================================================
// field positions in the mode/timing register
`define POWER_MODE_HI 7
`define POWER_MODE_LO 6
`define CLK_DIV_HI 5
`define CLK_DIV_LO 4
`define ACQ_LEN_HI 3
`define ACQ_LEN_LO 2
`define TIMER_TRIGGER_EN 1
`define EXT_TRIGGER_EN 0
// field positions in the channel/conversion register
`define DMA_EN_BIT 6
`define CONTINUOUS_BIT 5
`define SINGLE_BIT 4
// ==========================================================
// timing
`define CONV_CLOCKS 5'h11
`define CONVERT_START_N_MIN_NS 100
`define CLK_PERIOD_NS 100
`define CONVERT_START_N_MIN_CYCLES ((`CONVERT_START_N_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** adc_conv_pkg.sv ***
package adc_conv_pkg;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_acquire = 2'b01,
		st_convert = 2'b10
	} phase_e;
	typedef enum logic [1:0] {
		pm_off = 2'b00,
		pm_normal = 2'b01,
		pm_off_idle = 2'b10,
		pm_standby_idle = 2'b11
	} power_mode_e;
	typedef struct packed {
		logic [7:0] adc_mode_timing_control;
		logic [7:0] chan_conv;
		logic [7:0] result_high;
		logic [7:0] result_low;
		logic [7:0] offset_cal;
		logic [7:0] gain_cal;
		phase_e phase;
		logic [2:0] div_cnt;
		logic [4:0] step_cnt;
		logic [3:0] conv_chan;
		logic timer_seen;
		logic trig_pend;
		logic start_n_prev;
		logic [7:0] rdata;
		logic conv_done;
		logic [23:0] dma_addr;
	} state_s;
endpackage

// *** adc_conversion_control.sv ***
`timescale 1ns/10ps
`include "adc_conv_regs.svh"
module adc_conversion_control
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_write,
	input wire logic sfr_read,
	output logic [7:0] sfr_rdata,
	input wire logic timer2_overflow,
	input wire logic convert_start_n,
	input wire logic [11:0] sar_code,
	output logic [3:0] mux_channel,
	output logic track_hold,
	output logic sar_run,
	output logic adc_clk_tick,
	output logic reference_on,
	output logic analog_on,
	output logic standby,
	output logic conv_done,
	output logic dma_write,
	output logic [23:0] dma_addr,
	output logic [15:0] dma_data
);
	adc_conv_pkg::state_s cur;
	adc_conv_pkg::state_s nxt;
	logic [2:0] div_limit;
	logic [4:0] acq_limit;
	logic tick;
	logic start_req;
	logic busy;
	logic [1:0] pmode;
	logic [11:0] code;

	// ==========================================================
	// clock divider and timing decode
	always_comb
	begin
		case (cur.adc_mode_timing_control[`CLK_DIV_HI:`CLK_DIV_LO])
			2'b00: div_limit = 3'h0;
			2'b01: div_limit = 3'h1;
			2'b10: div_limit = 3'h3;
			default: div_limit = 3'h7;
		endcase
		case (cur.adc_mode_timing_control[`ACQ_LEN_HI:`ACQ_LEN_LO])
			2'b00: acq_limit = 5'h01;
			2'b01: acq_limit = 5'h02;
			2'b10: acq_limit = 5'h04;
			default: acq_limit = 5'h08;
		endcase
	end

	assign tick = (cur.div_cnt == div_limit);
	assign busy = (cur.phase != adc_conv_pkg::st_idle);
	assign pmode = cur.adc_mode_timing_control[`POWER_MODE_HI:`POWER_MODE_LO];
	assign code = sar_code;

	// ==========================================================
	// next-state logic
	always_comb
	begin
		nxt = cur;
		nxt.conv_done = 1'b0;
		nxt.start_n_prev = convert_start_n;
		nxt.div_cnt = tick ? 3'h0 : cur.div_cnt + 3'h1;
		start_req = 1'b0;
		// timer overflows counted in pairs, second one fires
		// hardware triggers are held pending so a slow adc clock cannot drop them
		if (cur.adc_mode_timing_control[`TIMER_TRIGGER_EN] && timer2_overflow && !busy)
		begin
			nxt.timer_seen = !cur.timer_seen;
			if (cur.timer_seen)
				nxt.trig_pend = 1'b1;
		end
		// falling edge of the start pin; pulses are assumed wider than one clock
		if (cur.adc_mode_timing_control[`EXT_TRIGGER_EN] && cur.start_n_prev && !convert_start_n && !busy)
			nxt.trig_pend = 1'b1;
		if (cur.trig_pend)
			start_req = 1'b1;
		if (cur.chan_conv[`SINGLE_BIT] || cur.chan_conv[`CONTINUOUS_BIT] || cur.chan_conv[`DMA_EN_BIT])
			start_req = 1'b1;
		if (pmode == adc_conv_pkg::pm_off)
		begin
			start_req = 1'b0;
			nxt.trig_pend = 1'b0;
		end
		case (cur.phase)
			adc_conv_pkg::st_idle:
			begin
				if (start_req && tick)
				begin
					nxt.phase = adc_conv_pkg::st_acquire;
					nxt.step_cnt = 5'h00;
					nxt.trig_pend = 1'b0;
					nxt.conv_chan = cur.chan_conv[3:0];
				end
			end
			adc_conv_pkg::st_acquire:
			begin
				if (tick)
				begin
					if (cur.step_cnt + 5'h01 == acq_limit)
					begin
						nxt.phase = adc_conv_pkg::st_convert;
						nxt.step_cnt = 5'h00;
					end
					else
						nxt.step_cnt = cur.step_cnt + 5'h01;
				end
			end
			adc_conv_pkg::st_convert:
			begin
				// later triggers are simply not looked at here
				if (tick)
				begin
					if (cur.step_cnt + 5'h01 == `CONV_CLOCKS)
					begin
						nxt.phase = adc_conv_pkg::st_idle;
						nxt.conv_done = 1'b1;
						nxt.result_high = {cur.conv_chan, code[11:8]};
						nxt.result_low = code[7:0];
						nxt.chan_conv[`SINGLE_BIT] = 1'b0;
						if (cur.chan_conv[`DMA_EN_BIT])
							nxt.dma_addr = cur.dma_addr + 24'h000002;
					end
					else
						nxt.step_cnt = cur.step_cnt + 5'h01;
				end
			end
			default: nxt.phase = adc_conv_pkg::st_idle;
		endcase
		if (!cur.chan_conv[`DMA_EN_BIT])
			nxt.dma_addr = 24'h000000;
		// register writes; hardware clear of the single bit wins over a write
		if (sfr_write)
		begin
			case (sfr_addr)
				`MODE_TIMING_ADDR: nxt.adc_mode_timing_control = sfr_wdata;
				`CHAN_CONV_ADDR:
				begin
					nxt.chan_conv = sfr_wdata;
					if (nxt.conv_done)
						nxt.chan_conv[`SINGLE_BIT] = 1'b0;
				end
				`OFFSET_CAL_ADDR: nxt.offset_cal = sfr_wdata;
				`GAIN_CAL_ADDR: nxt.gain_cal = sfr_wdata;
				default: nxt.rdata = cur.rdata;
			endcase
		end
		// registered read data; unmapped addresses read zero
		if (sfr_read)
		begin
			case (sfr_addr)
				`MODE_TIMING_ADDR: nxt.rdata = cur.adc_mode_timing_control;
				`CHAN_CONV_ADDR: nxt.rdata = cur.chan_conv;
				`RESULT_HIGH_ADDR: nxt.rdata = cur.result_high;
				`RESULT_LOW_ADDR: nxt.rdata = cur.result_low;
				`OFFSET_CAL_ADDR: nxt.rdata = cur.offset_cal;
				`GAIN_CAL_ADDR: nxt.rdata = cur.gain_cal;
				default: nxt.rdata = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cur <= '0;
			cur.adc_mode_timing_control <= `MODE_TIMING_RESET;
			cur.chan_conv <= `CHAN_CONV_RESET;
			cur.offset_cal <= `OFFSET_CAL_RESET;
			cur.gain_cal <= `GAIN_CAL_RESET;
			cur.phase <= adc_conv_pkg::st_idle;
			cur.start_n_prev <= 1'b1;
		end
		else
			cur <= nxt;
	end

	// ==========================================================
	// outputs; analog power follows mode and activity
	always_comb
	begin
		reference_on = 1'b1;
		case (pmode)
			adc_conv_pkg::pm_off: analog_on = 1'b0;
			adc_conv_pkg::pm_normal: analog_on = 1'b1;
			default: analog_on = busy;
		endcase
		standby = (pmode == adc_conv_pkg::pm_standby_idle) && !busy;
	end

	assign sfr_rdata = cur.rdata;
	assign mux_channel = cur.conv_chan;
	assign track_hold = (cur.phase == adc_conv_pkg::st_acquire);
	assign sar_run = (cur.phase == adc_conv_pkg::st_convert);
	assign adc_clk_tick = tick;
	assign conv_done = cur.conv_done;
	assign dma_write = cur.conv_done && cur.chan_conv[`DMA_EN_BIT];
	assign dma_addr = cur.dma_addr - 24'h000002;
	assign dma_data = {cur.result_high, cur.result_low};
endmodule

// *** adc_far_side.sv ***
`timescale 1ns/10ps
// ======================================
// timer overflow, start pin and converter core
module adc_far_side
(
	input wire logic clk,
	input wire logic ovf_req,
	input wire logic pin_req,
	output logic timer2_overflow,
	output logic convert_start_n,
	output logic [11:0] sar_code
);
	logic ovf_q = 1'b0;
	logic [1:0] low_left = 2'h0;
	// fixed code so every result bit is checkable
	assign sar_code = 12'hA5C;
	assign timer2_overflow = ovf_q;
	assign convert_start_n = (low_left == 2'h0);
	// low for two cycles: one alone would be exactly the 100 ns minimum, with no margin
	always @(negedge clk)
	begin
		ovf_q <= ovf_req;
		low_left <= pin_req ? 2'h2 : low_left - {1'b0, low_left != 2'h0};
	end
endmodule

// *** adc_conv_monitor.sv ***
`timescale 1ns/10ps
// ======================================
// watches the sequencing outputs
module adc_conv_monitor
(
	input wire logic clk,
	input wire logic reset,
	input wire logic track_hold,
	input wire logic sar_run,
	input wire logic adc_clk_tick,
	input wire logic reference_on,
	input wire logic standby,
	input wire logic conv_done,
	input wire logic dma_write
);
	logic [4:0] acq_cnt;
	logic [4:0] conv_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// adc ticks seen in the acquire and convert phases, read on the cycle after the phase ends
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			acq_cnt <= 5'h00;
			conv_cnt <= 5'h00;
		end
		else
		begin
			acq_cnt <= track_hold ? acq_cnt + {4'h0, adc_clk_tick} : 5'h00;
			conv_cnt <= sar_run ? conv_cnt + {4'h0, adc_clk_tick} : 5'h00;
		end
	end
	AST_REF_ON: assert property (reference_on) else $error("reference off");
	AST_DONE_ONE: assert property (conv_done |=> !conv_done) else $error("long done");
	AST_ACQ_THEN_CONV: assert property ($fell(track_hold) |-> sar_run) else $error("no conversion");
	AST_ACQ_LEN: assert property ($fell(track_hold) |-> $past(adc_clk_tick) &&
		acq_cnt inside {5'h01, 5'h02, 5'h04, 5'h08}) else $error("bad acquisition");
	AST_CONV_LEN: assert property ($fell(sar_run) |-> $past(adc_clk_tick) && conv_cnt == 5'h11)
		else $error("bad conversion");
	AST_DONE_AFTER: assert property ($fell(sar_run) |-> conv_done) else $error("no done");
	AST_STANDBY_IDLE: assert property (standby |-> !track_hold && !sar_run) else $error("busy");
	AST_DMA_DONE: assert property (dma_write |-> conv_done) else $error("stray dma");
endmodule
bind adc_conversion_control adc_conv_monitor i_adc_conv_monitor (.clk, .reset, .track_hold, .sar_run,
	.adc_clk_tick, .reference_on, .standby, .conv_done, .dma_write);

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_write = 1'b0;
	logic sfr_read = 1'b0;
	logic ovf_req = 1'b0;
	logic pin_req = 1'b0;
	logic timer2_overflow, convert_start_n, conv_done, hit;
	logic [11:0] sar_code;
	logic [7:0] sfr_rdata;
	logic [3:0] mux_channel;
	logic analog_on, standby, dma_write, got_dma;
	logic [23:0] dma_addr, got_addr;
	logic [15:0] dma_data, got_data;
	logic [3:0] got_chan;
	int miscompares = 0;
	int n_tests = 0;
	// ======================================
	// clock, far side and block
	always #50 clk = ~clk;
	adc_far_side i_adc_far_side (.clk, .ovf_req, .pin_req, .timer2_overflow, .convert_start_n, .sar_code);
	adc_conversion_control i_adc_conversion_control (.clk, .reset, .sfr_addr, .sfr_wdata, .sfr_write,
		.sfr_read, .sfr_rdata, .timer2_overflow, .convert_start_n, .sar_code, .mux_channel, .track_hold(),
		.sar_run(), .adc_clk_tick(), .reference_on(), .analog_on, .standby, .conv_done, .dma_write,
		.dma_addr, .dma_data);
	// ======================================
	// bus and check tasks
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_write = 1'b1;
		@(negedge clk);
		sfr_write = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(negedge clk);
		sfr_addr = a;
		sfr_read = 1'b1;
		@(negedge clk);
		sfr_read = 1'b0;
		check(what, sfr_rdata, exp);
	endtask
	// bounded wait; the slowest setting needs about 210 cycles
	task automatic wait_done;
		hit = 1'b0;
		for (int i = 0; i < 300 && hit !== 1'b1; i++)
		begin
			@(negedge clk);
			hit = conv_done;
			got_data = dma_data;
			got_addr = dma_addr;
			got_dma = dma_write;
			got_chan = mux_channel;
		end
	endtask
	task automatic fire(input logic ext);
		@(negedge clk);
		pin_req <= ext;
		ovf_req <= !ext;
		@(negedge clk);
		pin_req <= 1'b0;
		ovf_req <= 1'b0;
	endtask
	// ======================================
	// scenarios
	task automatic t_reset;
		rd(8'hEF, 8'h20, "mode");
		rd(8'hD8, 8'h00, "chan");
		rd(8'hF1, 8'h80, "offset");
		rd(8'hF3, 8'h80, "gain");
		rd(8'h80, 8'h00, "unmapped");
		$display("reset test done");
	endtask
	task automatic t_single;
		wr(8'hEF, 8'h40);
		wr(8'hD8, 8'h15);
		wait_done;
		check("single", {7'h00, hit}, 8'h01);
		rd(8'hDA, 8'h5A, "high");
		rd(8'hD9, 8'h5C, "low");
		rd(8'hD8, 8'h05, "go bit");
		$display("single test done");
	endtask
	task automatic t_trig;
		wr(8'hEF, 8'h42);
		wr(8'hD8, 8'h03);
		fire(1'b0);
		wait_done;
		check("first ovf", {7'h00, hit}, 8'h00);
		fire(1'b0);
		wait_done;
		check("second ovf", {7'h00, hit}, 8'h01);
		rd(8'hDA, 8'h3A, "high");
		wr(8'hEF, 8'h01);
		fire(1'b1);
		wait_done;
		check("off", {7'h00, hit}, 8'h00);
		wr(8'hEF, 8'h41);
		fire(1'b1);
		wait_done;
		check("pin", {7'h00, hit}, 8'h01);
		$display("trigger test done");
	endtask
	task automatic t_cont;
		wr(8'hEF, 8'hFC);
		wr(8'hD8, 8'h67);
		wait_done;
		check("dma write", {7'h00, got_dma}, 8'h01);
		check("dma high", got_data[15:8], 8'h7A);
		check("dma low", got_data[7:0], 8'h5C);
		check("dma addr0", got_addr[7:0], 8'h00);
		check("mux", {4'h0, got_chan}, 8'h07);
		wait_done;
		check("repeat", {7'h00, hit}, 8'h01);
		check("dma addr1", got_addr[7:0], 8'h02);
		wr(8'hD8, 8'h00);
		wait_done;
		wait_done;
		check("stopped", {7'h00, hit}, 8'h00);
		check("standby", {7'h00, standby}, 8'h01);
		check("analog off", {7'h00, analog_on}, 8'h00);
		$display("continuous test done");
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// about 1700 cycles expected
	initial
	begin
		#(4000 * 100);
		miscompares++;
		summarize;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		t_reset;
		t_single;
		t_trig;
		t_cont;
		summarize;
	end
endmodule
